// File: inc/wss_regs.svh
// Register offsets, field positions, reset values of the waveform steering block.
// Assumes word-aligned AHB-Lite addressing, one register per 32-bit word.
`ifndef WSS_REGS_SVH
`define WSS_REGS_SVH
`define WSS_ADDR_W 12
`define WSS_ADDR_STEER 12'h000
`define WSS_ADDR_CLKSEL 12'h004
`define WSS_ADDR_SRCSEL 12'h008
`define WSS_ADDR_CTRL 12'h00C
`define WSS_ADDR_STATUS 12'h010
`define WSS_STEER_OVR_HI 7
`define WSS_STEER_OVR_LO 4
`define WSS_STEER_EN_HI 3
`define WSS_STEER_EN_LO 0
`define WSS_CLKSEL_BIT 0
`define WSS_SRC_HI 3
`define WSS_SRC_LO 0
`define WSS_CTRL_POL_HI 3
`define WSS_CTRL_POL_LO 0
`define WSS_CTRL_MODE_HI 6
`define WSS_CTRL_MODE_LO 4
`define WSS_CTRL_LOAD_BIT 7
`define WSS_STEER_RESET 8'h00
`define WSS_CLKSEL_RESET 1'h0
`define WSS_SRC_RESET 4'h0
`define WSS_POL_RESET 4'h0
`define WSS_MODE_RESET 3'h0
`define WSS_MODE_STEER_SYNC 3'h0
`define WSS_MODE_STEER_BUF 3'h1
`endif

// File: inc/wss_pkg.sv
// Types shared by the waveform steering block.
// Assumes nothing beyond the register header.
package wss_pkg;
	typedef logic [3:0] wss_chan_t;
	typedef logic [2:0] wss_mode_t;
	typedef enum logic [3:0] {
		WSS_SRC_GENCLK = 4'h0,
		WSS_SRC_CAPTURE_COMPARE_1 = 4'h1,
		WSS_SRC_CCP2 = 4'h2,
		WSS_SRC_PWM3 = 4'h3,
		WSS_SRC_PWM4 = 4'h4,
		WSS_SRC_PWM5 = 4'h5,
		WSS_SRC_PWM6 = 4'h6,
		WSS_SRC_NCO = 4'h7,
		WSS_SRC_CMP1 = 4'h8,
		WSS_SRC_CMP2 = 4'h9,
		WSS_SRC_LC1 = 4'hA,
		WSS_SRC_LC2 = 4'hB,
		WSS_SRC_LC3 = 4'hC,
		WSS_SRC_LC4 = 4'hD,
		WSS_SRC_RSV0 = 4'hE,
		WSS_SRC_RSV1 = 4'hF
	} wss_src_t;
endpackage : wss_pkg

// File: inc/wss_ctrl_if.sv
// Control bundle between the register front end and its two datapath modules.
// Assumes all three ends run on clk_sys.
`timescale 1ns/10ps
`default_nettype none
interface wss_ctrl_if;
	import wss_pkg::*;
	wss_chan_t steerEnable;
	wss_chan_t overrideLevel;
	wss_chan_t invertOutput;
	wss_mode_t mode;
	logic loadReq;
	logic genTick;
	logic [3:0] sourceCode;
	logic loadDone;
	wss_chan_t effEnable;
	wss_chan_t pinLevel;
	logic dataWave;
	modport regs (
		output steerEnable, overrideLevel, invertOutput, mode, loadReq, genTick, sourceCode,
		input loadDone, effEnable, pinLevel, dataWave
	);
	modport steer (
		input steerEnable, overrideLevel, invertOutput, mode, loadReq, genTick, dataWave,
		output loadDone, effEnable, pinLevel
	);
	modport srcsel (
		input sourceCode,
		output dataWave
	);
endinterface : wss_ctrl_if
`default_nettype wire

// File: rtl/wss_srcsel.sv
// Waveform source selector: picks the internal data waveform from on-chip sources.
// Assumes all sources are synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module wss_srcsel
	import wss_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Sources
	input wire logic genClockIn,
	input wire logic [1:0] captureCompare,
	input wire logic [3:0] pwmOut,
	input wire logic numericOscillator,
	input wire logic [1:0] comparatorOut,
	input wire logic [3:0] logicCellResult,
	// Control
	wss_ctrl_if.srcsel ctrl
);
	logic [15:0] srcVec;
	// Reserved codes land on the two zero slots
	assign srcVec = {2'h0, logicCellResult, comparatorOut, numericOscillator, pwmOut,
		captureCompare, genClockIn};

	always_ff @(posedge clk_sys) begin
		if (reset)
			ctrl.dataWave <= 1'b0;
		else
			ctrl.dataWave <= srcVec[ctrl.sourceCode];
	end

	property p_rsvSilent;
		@(posedge clk_sys) disable iff (reset)
		(ctrl.sourceCode[3:1] == 3'h7) |=> !ctrl.dataWave;
	endproperty
	a_rsvSilent: assert property (p_rsvSilent) else $error("reserved source drove data");

	property p_ncoPicked;
		@(posedge clk_sys) disable iff (reset)
		(ctrl.sourceCode == 4'h7) |=> ctrl.dataWave == $past(numericOscillator);
	endproperty
	a_ncoPicked: assert property (p_ncoPicked) else $error("oscillator source not followed");
endmodule : wss_srcsel
`default_nettype wire

// File: rtl/wss_steer.sv
// Output steering: per channel waveform with polarity, or static override level.
// Assumes genTick is a one-cycle enable at the generator clock rate.
`timescale 1ns/10ps
`default_nettype none
`include "wss_regs.svh"
module wss_steer
	import wss_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Control
	wss_ctrl_if.steer ctrl
);
	logic steerMode;
	logic bufMode;
	wss_chan_t shadow;
	wss_chan_t next_pin;

	assign steerMode = (ctrl.mode[2:1] == 2'h0);
	assign bufMode = (ctrl.mode == `WSS_MODE_STEER_BUF);
	assign ctrl.effEnable = bufMode ? shadow : ctrl.steerEnable;
	assign ctrl.loadDone = bufMode && ctrl.loadReq && ctrl.genTick;

	// Shadow tracks the register outside mode 001 so entering it is glitch free
	always_ff @(posedge clk_sys) begin
		if (reset)
			shadow <= 4'(`WSS_STEER_RESET);
		else if (ctrl.genTick && (!bufMode || ctrl.loadReq))
			shadow <= ctrl.steerEnable;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_chan
			always_comb begin
				if (steerMode && !ctrl.effEnable[gi])
					next_pin[gi] = ctrl.overrideLevel[gi];
				else
					next_pin[gi] = ctrl.dataWave ^ ctrl.invertOutput[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (reset)
			ctrl.pinLevel <= 4'h0;
		else if (ctrl.genTick)
			ctrl.pinLevel <= next_pin;
	end

	property p_overrideOut;
		@(posedge clk_sys) disable iff (reset)
		(ctrl.genTick && steerMode && !ctrl.effEnable[0])
			|=> ctrl.pinLevel[0] == $past(ctrl.overrideLevel[0]);
	endproperty
	a_overrideOut: assert property (p_overrideOut) else $error("override level not driven");

	property p_waveOut;
		@(posedge clk_sys) disable iff (reset)
		(ctrl.genTick && steerMode && ctrl.effEnable[3])
			|=> ctrl.pinLevel[3] == ($past(ctrl.dataWave) ^ $past(ctrl.invertOutput[3]));
	endproperty
	a_waveOut: assert property (p_waveOut) else $error("steered waveform wrong");

	property p_nonSteer;
		@(posedge clk_sys) disable iff (reset)
		(ctrl.genTick && !steerMode)
			|=> ctrl.pinLevel[1] == ($past(ctrl.dataWave) ^ $past(ctrl.invertOutput[1]));
	endproperty
	a_nonSteer: assert property (p_nonSteer) else $error("steering acted outside steer mode");

	property p_bufHold;
		@(posedge clk_sys) disable iff (reset)
		(bufMode && !ctrl.loadReq && $stable(ctrl.mode)) |=> $stable(shadow);
	endproperty
	a_bufHold: assert property (p_bufHold) else $error("buffered enable changed early");
endmodule : wss_steer
`default_nettype wire

// File: rtl/wss_top.sv
// Waveform steering, clock select and input select with an AHB-Lite register slave.
// Assumes a single AHB-Lite master, word transfers, and a fast oscillator tick
// already synchronous to clk_sys as a one-cycle enable.
//
// Functional notes
// - Steer enable 1 sends the data waveform, with channel polarity, to the output.
// - Steer enable 0 drives the output to its override level bit.
// - Steering register: overrides D..A in bits 7..4, enables D..A in 3..0.
// - Steering and override bits act only when mode is 000 or 001.
// - In mode 001 enables reach outputs only at a later buffer load.
// - Clock-select bit 0 picks fast oscillator when 1, system clock when 0.
// - Unused upper bits of clock and input select ignore writes, read zero.
// - Four-bit source code picks clock, compare, PWM, oscillator, comparator, logic cell.
// - Source codes 1110 and 1111 connect no source.
// - Polarity bit 1 inverts the steered waveform, 0 passes it.
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "wss_regs.svh"
module wss_top
	import wss_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Generator clock source
	input wire logic fastInternalOscillator,
	// Waveform sources
	input wire logic genClockIn,
	input wire logic [1:0] captureCompare,
	input wire logic [3:0] pwmOut,
	input wire logic numericOscillator,
	input wire logic [1:0] comparatorOut,
	input wire logic [3:0] logicCellResult,
	// Steered outputs
	output logic outputA,
	output logic outputB,
	output logic outputC,
	output logic outputD
);
	wss_ctrl_if ctrl();

	// Register state
	logic [7:0] steerReg;
	logic clkSelect;
	logic [3:0] sourceCode;
	wss_chan_t polarity;
	wss_mode_t mode;
	logic loadReq;

	// Bus data phase state
	logic wrPend;
	logic rdPend;
	logic [`WSS_ADDR_W-1:0] dataAddr;
	logic addrValid;
	logic [31:0] next_rdata;

	function automatic logic isAddr(input logic [`WSS_ADDR_W-1:0] a,
		input logic [`WSS_ADDR_W-1:0] off);
		isAddr = (a == off);
	endfunction : isAddr

	// Zero-wait slave: no stall source exists in this block
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrValid = hsel && htrans[1] && hready;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wrPend <= 1'b0;
			rdPend <= 1'b0;
			dataAddr <= 12'h000;
		end else if (hready) begin
			wrPend <= addrValid && hwrite;
			rdPend <= addrValid && !hwrite;
			dataAddr <= haddr[`WSS_ADDR_W-1:0];
		end
	end

	// Steering register is written in every mode and never cleared by mode changes
	always_ff @(posedge clk_sys) begin
		if (reset)
			steerReg <= `WSS_STEER_RESET;
		else if (wrPend && isAddr(dataAddr, `WSS_ADDR_STEER))
			steerReg <= hwdata[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			clkSelect <= `WSS_CLKSEL_RESET;
		else if (wrPend && isAddr(dataAddr, `WSS_ADDR_CLKSEL))
			clkSelect <= hwdata[`WSS_CLKSEL_BIT];
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			sourceCode <= `WSS_SRC_RESET;
		else if (wrPend && isAddr(dataAddr, `WSS_ADDR_SRCSEL))
			sourceCode <= hwdata[`WSS_SRC_HI:`WSS_SRC_LO];
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			polarity <= `WSS_POL_RESET;
			mode <= `WSS_MODE_RESET;
		end else if (wrPend && isAddr(dataAddr, `WSS_ADDR_CTRL)) begin
			polarity <= hwdata[`WSS_CTRL_POL_HI:`WSS_CTRL_POL_LO];
			mode <= hwdata[`WSS_CTRL_MODE_HI:`WSS_CTRL_MODE_LO];
		end
	end

	// Load request: a fresh software set wins over the hardware clear
	always_ff @(posedge clk_sys) begin
		if (reset)
			loadReq <= 1'b0;
		else if (wrPend && isAddr(dataAddr, `WSS_ADDR_CTRL) && hwdata[`WSS_CTRL_LOAD_BIT])
			loadReq <= 1'b1;
		else if (ctrl.loadDone)
			loadReq <= 1'b0;
	end

	// Read mux; reads see writes of the previous data phase already stored
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rdPend) begin
			if (isAddr(dataAddr, `WSS_ADDR_STEER))
				next_rdata[7:0] = steerReg;
			else if (isAddr(dataAddr, `WSS_ADDR_CLKSEL))
				next_rdata[`WSS_CLKSEL_BIT] = clkSelect;
			else if (isAddr(dataAddr, `WSS_ADDR_SRCSEL))
				next_rdata[`WSS_SRC_HI:`WSS_SRC_LO] = sourceCode;
			else if (isAddr(dataAddr, `WSS_ADDR_CTRL))
				next_rdata[7:0] = {loadReq, mode, polarity};
			else if (isAddr(dataAddr, `WSS_ADDR_STATUS))
				next_rdata[12:0] = {ctrl.effEnable, ctrl.dataWave, clkSelect, 3'h0,
					ctrl.pinLevel};
		end
	end
	assign hrdata = next_rdata;

	// Generator clock as an enable: every cycle, or each fast oscillator tick
	assign ctrl.genTick = clkSelect ? fastInternalOscillator : 1'b1;

	assign ctrl.steerEnable = steerReg[`WSS_STEER_EN_HI:`WSS_STEER_EN_LO];
	assign ctrl.overrideLevel = steerReg[`WSS_STEER_OVR_HI:`WSS_STEER_OVR_LO];
	assign ctrl.invertOutput = polarity;
	assign ctrl.mode = mode;
	assign ctrl.loadReq = loadReq;
	assign ctrl.sourceCode = sourceCode;

	wss_srcsel u_srcsel (
		.clk_sys(clk_sys),
		.reset(reset),
		.genClockIn(genClockIn),
		.captureCompare(captureCompare),
		.pwmOut(pwmOut),
		.numericOscillator(numericOscillator),
		.comparatorOut(comparatorOut),
		.logicCellResult(logicCellResult),
		.ctrl(ctrl.srcsel)
	);

	wss_steer u_steer (
		.clk_sys(clk_sys),
		.reset(reset),
		.ctrl(ctrl.steer)
	);

	assign outputA = ctrl.pinLevel[0];
	assign outputB = ctrl.pinLevel[1];
	assign outputC = ctrl.pinLevel[2];
	assign outputD = ctrl.pinLevel[3];

	property p_steerWrite;
		@(posedge clk_sys) disable iff (reset)
		(wrPend && isAddr(dataAddr, `WSS_ADDR_STEER)) |=> steerReg == $past(hwdata[7:0]);
	endproperty
	a_steerWrite: assert property (p_steerWrite) else $error("steering write lost");

	property p_clkUpperZero;
		@(posedge clk_sys) disable iff (reset)
		(rdPend && isAddr(dataAddr, `WSS_ADDR_CLKSEL)) |-> hrdata[31:1] == 31'h0;
	endproperty
	a_clkUpperZero: assert property (p_clkUpperZero) else $error("clock select upper bits set");

	property p_srcUpperZero;
		@(posedge clk_sys) disable iff (reset)
		(rdPend && isAddr(dataAddr, `WSS_ADDR_SRCSEL))
			|-> hrdata[31:4] == 28'h0 && hrdata[3:0] == sourceCode;
	endproperty
	a_srcUpperZero: assert property (p_srcUpperZero) else $error("source select read wrong");

	property p_fastGate;
		@(posedge clk_sys) disable iff (reset)
		(clkSelect && !fastInternalOscillator) |-> !ctrl.genTick ##1
			(clkSelect && !fastInternalOscillator) |-> $stable(ctrl.pinLevel);
	endproperty
	a_fastGate: assert property (p_fastGate) else $error("outputs moved without fast tick");

	property p_sysClk;
		@(posedge clk_sys) disable iff (reset)
		!clkSelect |-> ctrl.genTick;
	endproperty
	a_sysClk: assert property (p_sysClk) else $error("system clock tick missing");

	property p_keepInOtherMode;
		@(posedge clk_sys) disable iff (reset)
		(mode[2:1] != 2'h0 && !(wrPend && isAddr(dataAddr, `WSS_ADDR_STEER)))
			|=> $stable(steerReg);
	endproperty
	a_keepInOtherMode: assert property (p_keepInOtherMode) else $error("steering lost in mode");

	property p_loadClears;
		@(posedge clk_sys) disable iff (reset)
		(loadReq && mode == `WSS_MODE_STEER_BUF && ctrl.genTick
			&& !(wrPend && isAddr(dataAddr, `WSS_ADDR_CTRL)))
			|=> !loadReq && ctrl.effEnable == $past(steerReg[3:0]);
	endproperty
	a_loadClears: assert property (p_loadClears) else $error("buffer load not taken");

	// Pin and bus level checks, so a broken submodule shows at the top too
	property p_steerRead;
		@(posedge clk_sys) disable iff (reset)
		(rdPend && isAddr(dataAddr, `WSS_ADDR_STEER)) |-> hrdata == {24'h000000, steerReg};
	endproperty
	a_steerRead: assert property (p_steerRead) else $error("steering read wrong");

	property p_clkWrite;
		@(posedge clk_sys) disable iff (reset)
		(wrPend && isAddr(dataAddr, `WSS_ADDR_CLKSEL)) |=> clkSelect == $past(hwdata[0]);
	endproperty
	a_clkWrite: assert property (p_clkWrite) else $error("clock select write lost");

	property p_clkRead;
		@(posedge clk_sys) disable iff (reset)
		(rdPend && isAddr(dataAddr, `WSS_ADDR_CLKSEL)) |-> hrdata[0] == clkSelect;
	endproperty
	a_clkRead: assert property (p_clkRead) else $error("clock select read wrong");

	property p_srcWrite;
		@(posedge clk_sys) disable iff (reset)
		(wrPend && isAddr(dataAddr, `WSS_ADDR_SRCSEL)) |=> sourceCode == $past(hwdata[3:0]);
	endproperty
	a_srcWrite: assert property (p_srcWrite) else $error("source write lost");

	property p_overrideB;
		@(posedge clk_sys) disable iff (reset)
		(ctrl.genTick && mode[2:1] == 2'h0 && !ctrl.effEnable[1])
			|=> outputB == $past(steerReg[5]);
	endproperty
	a_overrideB: assert property (p_overrideB) else $error("override B wrong");

	property p_waveC;
		@(posedge clk_sys) disable iff (reset)
		(ctrl.genTick && mode[2:1] == 2'h0 && ctrl.effEnable[2])
			|=> outputC == ($past(ctrl.dataWave) ^ $past(polarity[2]));
	endproperty
	a_waveC: assert property (p_waveC) else $error("steered C wrong");

	property p_nonSteerD;
		@(posedge clk_sys) disable iff (reset)
		(ctrl.genTick && mode[2:1] != 2'h0)
			|=> outputD == ($past(ctrl.dataWave) ^ $past(polarity[3]));
	endproperty
	a_nonSteerD: assert property (p_nonSteerD) else $error("output D steered in mode");

	property p_syncEnable;
		@(posedge clk_sys) disable iff (reset)
		(mode == `WSS_MODE_STEER_SYNC) |-> ctrl.effEnable == steerReg[3:0];
	endproperty
	a_syncEnable: assert property (p_syncEnable) else $error("enables not direct");

	property p_bufNoWrite;
		@(posedge clk_sys) disable iff (reset)
		(mode == `WSS_MODE_STEER_BUF && !loadReq && wrPend && isAddr(dataAddr, `WSS_ADDR_STEER))
			|=> $stable(ctrl.effEnable);
	endproperty
	a_bufNoWrite: assert property (p_bufNoWrite) else $error("buffered write leaked");

	property p_loadWaits;
		@(posedge clk_sys) disable iff (reset)
		(loadReq && !ctrl.genTick) |=> loadReq;
	endproperty
	a_loadWaits: assert property (p_loadWaits) else $error("load taken without tick");

	property p_genClkSrc;
		@(posedge clk_sys) disable iff (reset)
		(sourceCode == 4'h0) |=> ctrl.dataWave == $past(genClockIn);
	endproperty
	a_genClkSrc: assert property (p_genClkSrc) else $error("clock source wrong");

	property p_ccpSrc;
		@(posedge clk_sys) disable iff (reset)
		(sourceCode == 4'h2) |=> ctrl.dataWave == $past(captureCompare[1]);
	endproperty
	a_ccpSrc: assert property (p_ccpSrc) else $error("compare source wrong");

	property p_pwmSrc;
		@(posedge clk_sys) disable iff (reset)
		(sourceCode == 4'h3) |=> ctrl.dataWave == $past(pwmOut[0]);
	endproperty
	a_pwmSrc: assert property (p_pwmSrc) else $error("pwm source wrong");

	property p_cmpSrc;
		@(posedge clk_sys) disable iff (reset)
		(sourceCode == 4'h9) |=> ctrl.dataWave == $past(comparatorOut[1]);
	endproperty
	a_cmpSrc: assert property (p_cmpSrc) else $error("comparator source wrong");

	property p_lcSrc;
		@(posedge clk_sys) disable iff (reset)
		(sourceCode == 4'hD) |=> ctrl.dataWave == $past(logicCellResult[3]);
	endproperty
	a_lcSrc: assert property (p_lcSrc) else $error("logic cell source wrong");
endmodule : wss_top
`default_nettype wire

// File: test/wss_gate_model.sv
// Gate driver model: the power stage inputs that the four steered pins feed.
// Assumes the pins are levels synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module wss_gate_model (
	// Clock
	input wire logic clk_sys,
	// Steered pins, D..A
	input wire logic [3:0] pinIn,
	// Levels taken by the drivers, D..A
	output logic [3:0] gateLevel
);
	// One input flop, like a real driver stage; costs a cycle of latency
	always_ff @(posedge clk_sys) begin
		gateLevel <= pinIn;
	end
endmodule : wss_gate_model
`default_nettype wire

// File: test/wss_top_test.sv
// Bench for the steering block: register access and steered pin levels.
// Assumes an AHB-Lite slave that answers through hreadyout with OKAY.
`timescale 1ns/10ps
`default_nettype none
`include "wss_regs.svh"
module wss_top_test;
	import wss_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic fastOsc = 1'b0;
	logic [15:0] src = 16'h0;
	wire logic hreadyout;
	wire logic hresp;
	wire logic [31:0] hrdata;
	wire logic [3:0] pins;
	wire logic [3:0] gate;
	int error_cnt = 0;
	int samples_checked = 0;

	// Source vector index equals the source code that selects it
	wss_top dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.fastInternalOscillator(fastOsc), .genClockIn(src[0]),
		.captureCompare(src[2:1]), .pwmOut(src[6:3]), .numericOscillator(src[7]),
		.comparatorOut(src[9:8]), .logicCellResult(src[13:10]),
		.outputA(pins[0]), .outputB(pins[1]), .outputC(pins[2]), .outputD(pins[3]));
	wss_gate_model gdrv (.clk_sys(clk_sys), .pinIn(pins), .gateLevel(gate));

	always #10 clk_sys = ~clk_sys;

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One single transfer; waits on hready, never on a fixed count
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		r = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask : wr

	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		check(n, r, e);
	endtask : rdc

	task automatic ctl(input logic ld, input logic [2:0] m, input logic [3:0] p);
		wr(`WSS_ADDR_CTRL, {24'h0, ld, m, p});
	endtask : ctl

	// Source to pin is two ticks, plus the driver flop
	task automatic pinc(input string n, input logic [3:0] e);
		repeat (4) @(posedge clk_sys);
		check(n, {28'h0, gate}, {28'h0, e});
	endtask : pinc

	task automatic results;
		$display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// Whole run is well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		results();
	end

	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		rdc("steer", `WSS_ADDR_STEER, 32'h0);
		rdc("clksel", `WSS_ADDR_CLKSEL, 32'h0);
		rdc("srcsel", `WSS_ADDR_SRCSEL, 32'h0);
		wr(`WSS_ADDR_CLKSEL, 32'hFFFFFFFE);
		rdc("clksel", `WSS_ADDR_CLKSEL, 32'h0);
		wr(`WSS_ADDR_SRCSEL, 32'hFFFFFFF5);
		rdc("srcsel", `WSS_ADDR_SRCSEL, 32'h5);
		wr(12'h020, 32'hFFFFFFFF);
		rdc("unmapped", 12'h020, 32'h0);
		wr(`WSS_ADDR_STEER, 32'h0F);
		rdc("steer", `WSS_ADDR_STEER, 32'h0F);
		// Lone high source, then lone low source, for every code
		for (int c = 0; c < 16; c++) begin
			wr(`WSS_ADDR_SRCSEL, 32'(c));
			src <= 16'h1 << c;
			pinc("src high", (c < 14) ? 4'hF : 4'h0);
			src <= ~(16'h1 << c);
			pinc("src low", 4'h0);
		end
		wr(`WSS_ADDR_SRCSEL, 32'h0);
		src <= 16'h1;
		ctl(1'b0, 3'h0, 4'h5);
		pinc("polarity", 4'hA);
		wr(`WSS_ADDR_STEER, 32'h6A);
		pinc("override", 4'hE);
		// Non-steering mode: waveform everywhere, register kept
		ctl(1'b0, 3'h2, 4'h5);
		pinc("mode 2", 4'hA);
		rdc("steer kept", `WSS_ADDR_STEER, 32'h6A);
		ctl(1'b0, 3'h0, 4'h5);
		pinc("mode 0 again", 4'hE);
		// Overrides unchanged so only the enable buffer shows
		ctl(1'b0, 3'h1, 4'h0);
		wr(`WSS_ADDR_STEER, 32'h6F);
		pinc("buffered", 4'hE);
		ctl(1'b1, 3'h1, 4'h0);
		pinc("loaded", 4'hF);
		rdc("ctrl", `WSS_ADDR_CTRL, 32'h10);
		rdc("status", `WSS_ADDR_STATUS, 32'h1F0F);
		ctl(1'b0, 3'h0, 4'h0);
		wr(`WSS_ADDR_CLKSEL, 32'h1);
		rdc("clksel", `WSS_ADDR_CLKSEL, 32'h1);
		src <= 16'h0;
		pinc("no tick", 4'hF);
		repeat (2) begin
			fastOsc <= 1'b1;
			@(posedge clk_sys);
			fastOsc <= 1'b0;
			@(posedge clk_sys);
		end
		pinc("tick", 4'h0);
		results();
	end
endmodule : wss_top_test
`default_nettype wire
